// >>> core/plc_pkg.sv
// Package for the link capability register: offsets, fields, resets, carriers
// Operation
// - Bits 3:0 read a fixed top speed code of 1 (2.5 Gbps).
// - Bits 9:4 hold a lockable lane count, starting at the port's width.
// - A zero, reserved or invalid lane count trains the link as one lane.
// - A written lane count can force a narrower link than the physical width.
// - Bits 11:10 always read 3: both low power states supported.
// - Bits 14:12 read 5 with separate clocks, 3 with a common clock.
// - Bits 17:15 hold the sleep exit delay, resetting to 2.
// - Bit 18 reads zero: reference clock removal is not tolerated.
// - Bit 19 resets to 1 downstream and 0 upstream.
// - Bit 20 resets to 1 downstream and stays zero upstream.
// - Bit 21 resets to 1 downstream and 0 upstream.
// - In revision 1.1 compatibility mode bit 21 resets to zero everywhere.
// - Bits 31:24 read the owning port number, 0 to 6.
package plc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] LINK_CAP_IDX = 12'h04c;
  localparam logic [ADDR_W-1:0] LINK_CAP_ADDR = 12'h130;
  localparam int SPEED_LSB = 0;
  localparam int SPEED_MSB = 3;
  localparam int WIDTH_LSB = 4;
  localparam int WIDTH_MSB = 9;
  localparam int ASPM_LSB = 10;
  localparam int ASPM_MSB = 11;
  localparam int L0S_LSB = 12;
  localparam int L0S_MSB = 14;
  localparam int L1_LSB = 15;
  localparam int L1_MSB = 17;
  localparam int CPM_BIT = 18;
  localparam int SDOWN_BIT = 19;
  localparam int ALIVE_BIT = 20;
  localparam int BWN_BIT = 21;
  localparam int PORT_LSB = 24;
  localparam int PORT_MSB = 31;
  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
  localparam logic [2:0] L0S_SEPARATE = 3'h5;
  localparam logic [2:0] L0S_COMMON = 3'h3;
  localparam logic [2:0] L1_RESET = 3'h2;
  localparam logic REFCLK_REMOVAL = 1'h0;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [5:0] WIDTH_X2 = 6'h02;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;
  localparam logic [5:0] WIDTH_X12 = 6'h0c;
  localparam logic [5:0] WIDTH_X16 = 6'h10;
  localparam logic [5:0] WIDTH_X32 = 6'h20;
  localparam logic [7:0] PORT_MAX = 8'h06;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } plc_bus_s;

  typedef struct packed {
    logic [7:0] port_index;
    logic [5:0] phys_width;
    logic upstream;
    logic compat_1p1;
  } plc_strap_s;

  function automatic logic plc_width_valid(input logic [5:0] code);
    plc_width_valid = (code == WIDTH_X1) || (code == WIDTH_X2) ||
      (code == WIDTH_X4) || (code == WIDTH_X8) || (code == WIDTH_X12) ||
      (code == WIDTH_X16) || (code == WIDTH_X32);
  endfunction

  function automatic logic plc_hit(input plc_bus_s b);
    plc_hit = (b.addr == LINK_CAP_ADDR);
  endfunction
endpackage

// >>> core/plc_link_cap.sv
// Link capability register for one switch port, with trained width output
`timescale 1ns/1ps
module plc_link_cap (
  input wire logic clk_in, // Core clock, 250 MHz
  input wire logic rst_n_in, // Asynchronous reset, active low
  input wire logic en_in, // Clock enable, freezes all state when low
  input wire plc_pkg::plc_bus_s bus_in, // Register access request
  input wire plc_pkg::plc_strap_s strap_in, // Port straps, caught after reset
  input wire logic unlock_in, // Register unlock control
  input wire logic common_clk_in, // Common reference clock in use
  output logic [31:0] rdata_out, // Read data, valid the cycle after a read
  output logic [5:0] train_width_out, // Lane count the link trains at
  output logic loaded_out // Straps captured, register usable
);
  import plc_pkg::*;

  logic loaded_q;
  logic up_q;
  logic [7:0] port_q;
  logic [5:0] phys_q;
  logic [5:0] width_q;
  logic [2:0] l1_q;
  logic sdown_q;
  logic alive_q;
  logic bwn_q;
  logic [31:0] rdata_q;
  logic [5:0] train_q;
  logic [5:0] train_d;
  logic [31:0] cap_word;
  logic wr_hit;
  logic rd_hit;
  logic wr_open;

  assign wr_hit = en_in && bus_in.wr && plc_hit(bus_in);
  assign rd_hit = en_in && bus_in.rd && plc_hit(bus_in);
  // Writes before the straps land would be overwritten, so they are dropped
  assign wr_open = wr_hit && unlock_in && loaded_q;

  // Straps are caught on the first enabled edge after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loaded_q <= 1'b0;
      up_q <= 1'b0;
      port_q <= 8'h00;
      phys_q <= WIDTH_X1;
    end else if (en_in && !loaded_q) begin
      loaded_q <= 1'b1;
      up_q <= strap_in.upstream;
      port_q <= strap_in.port_index;
      phys_q <= strap_in.phys_width;
    end
  end

  // Lane count field: starts at the physical width, writable when unlocked
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      width_q <= WIDTH_X1;
    end else if (en_in && !loaded_q) begin
      width_q <= strap_in.phys_width;
    end else if (wr_open) begin
      width_q <= bus_in.wdata[WIDTH_MSB:WIDTH_LSB];
    end
  end

  // Sleep exit delay, lockable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      l1_q <= L1_RESET;
    end else if (en_in && !loaded_q) begin
      l1_q <= L1_RESET;
    end else if (wr_open) begin
      l1_q <= bus_in.wdata[L1_MSB:L1_LSB];
    end
  end

  // Port role capability bits; upstream keeps link alive and bandwidth bits at zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sdown_q <= 1'b0;
      alive_q <= 1'b0;
      bwn_q <= 1'b0;
    end else if (en_in && !loaded_q) begin
      sdown_q <= !strap_in.upstream;
      alive_q <= !strap_in.upstream;
      bwn_q <= !strap_in.upstream && !strap_in.compat_1p1;
    end else if (wr_open) begin
      sdown_q <= bus_in.wdata[SDOWN_BIT];
      alive_q <= bus_in.wdata[ALIVE_BIT] && !up_q;
      bwn_q <= bus_in.wdata[BWN_BIT] && !up_q;
    end
  end

  always_comb begin
    cap_word = ZERO_WORD;
    cap_word[SPEED_MSB:SPEED_LSB] = SPEED_GEN1;
    cap_word[WIDTH_MSB:WIDTH_LSB] = width_q;
    cap_word[ASPM_MSB:ASPM_LSB] = ASPM_L0S_L1;
    // Follows the clock mode live, so a mode change needs no rewrite
    cap_word[L0S_MSB:L0S_LSB] = common_clk_in ? L0S_COMMON : L0S_SEPARATE;
    cap_word[L1_MSB:L1_LSB] = l1_q;
    cap_word[CPM_BIT] = REFCLK_REMOVAL;
    cap_word[SDOWN_BIT] = sdown_q;
    cap_word[ALIVE_BIT] = alive_q;
    cap_word[BWN_BIT] = bwn_q;
    cap_word[PORT_MSB:PORT_LSB] = port_q;
  end

  // Read data stands for one cycle only; unmapped reads return zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= ZERO_WORD;
    end else if (en_in) begin
      rdata_q <= rd_hit ? cap_word : ZERO_WORD;
    end
  end

  // Invalid codes fall back to one lane; a wider code than fitted is clipped
  always_comb begin
    if (!plc_width_valid(width_q)) begin
      train_d = WIDTH_X1;
    end else if (width_q > phys_q) begin
      train_d = phys_q;
    end else begin
      train_d = width_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      train_q <= WIDTH_X1;
    end else if (en_in) begin
      train_q <= train_d;
    end
  end

  assign rdata_out = rdata_q;
  assign train_width_out = train_q;
  assign loaded_out = loaded_q;

  chk_speed_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=> rdata_q[SPEED_MSB:SPEED_LSB] == 4'h1)
    else $error("top speed code not 1");

  chk_width_strap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q) |=> width_q == $past(strap_in.phys_width))
    else $error("lane count not loaded from physical width");

  chk_width_unlocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_open && !$past(wr_open)) |=> ##0 width_q == $past(bus_in.wdata[9:4]))
    else $error("unlocked write did not update lane count");

  chk_width_locked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_hit && !unlock_in && loaded_q) |=> $stable(width_q) && $stable(l1_q))
    else $error("locked write changed a field");

  chk_train_invalid: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !plc_width_valid(width_q)) |=> train_q == 6'h01)
    else $error("invalid lane count did not train one lane");

  chk_train_narrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && plc_width_valid(width_q) && width_q <= phys_q) |=> train_q == $past(width_q))
    else $error("narrow lane count not applied");

  chk_aspm_fixed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=> rdata_q[ASPM_MSB:ASPM_LSB] == 2'h3)
    else $error("low power support not 3");

  chk_l0s_clock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=> rdata_q[L0S_MSB:L0S_LSB] == ($past(common_clk_in) ? 3'h3 : 3'h5))
    else $error("standby exit delay wrong for clock mode");

  chk_l1_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(loaded_q) |-> l1_q == 3'h2)
    else $error("sleep exit delay not 2 after load");

  chk_cpm_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=> !rdata_q[CPM_BIT])
    else $error("refclk removal bit set");

  chk_role_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(loaded_q) |-> sdown_q == !up_q && alive_q == !up_q)
    else $error("role bits wrong after load");

  chk_up_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (loaded_q && up_q) |-> !alive_q && !bwn_q)
    else $error("upstream reports link alive or bandwidth");

  chk_bwn_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q) |=> bwn_q == (!$past(strap_in.upstream) && !$past(strap_in.compat_1p1)))
    else $error("bandwidth notify bit wrong after load");

  chk_compat_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q && strap_in.compat_1p1) |=> !bwn_q)
    else $error("bandwidth notify set in compatibility mode");

  chk_port_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_hit && loaded_q) |=> rdata_q[PORT_MSB:PORT_LSB] == port_q)
    else $error("port index read wrong");

  chk_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !rd_hit) |=> rdata_q == 32'h0000_0000)
    else $error("read data not zero outside a hit");

  chk_width_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[WIDTH_MSB:WIDTH_LSB] == $past(width_q))
    else $error("lane count read wrong");

  chk_train_clip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && plc_width_valid(width_q) && width_q > phys_q) |=>
    train_q == $past(phys_q))
    else $error("wide lane count not clipped to physical width");

  chk_l1_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[L1_MSB:L1_LSB] == $past(l1_q))
    else $error("sleep exit delay read wrong");

  chk_l1_unlocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open |=>
    l1_q == $past(bus_in.wdata[L1_MSB:L1_LSB]))
    else $error("unlocked write did not update sleep exit delay");

  chk_resv_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[PORT_LSB-1:BWN_BIT+1] == '0)
    else $error("reserved bits not zero");

  chk_sdown_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[SDOWN_BIT] == $past(sdown_q))
    else $error("sudden loss bit read wrong");

  chk_alive_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[ALIVE_BIT] == $past(alive_q))
    else $error("link alive bit read wrong");

  chk_bwn_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_hit |=>
    rdata_q[BWN_BIT] == $past(bwn_q))
    else $error("bandwidth notify bit read wrong");

  chk_sdown_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q) |=>
    sdown_q == !$past(strap_in.upstream))
    else $error("sudden loss bit wrong after load");

  chk_alive_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q) |=>
    alive_q == !$past(strap_in.upstream))
    else $error("link alive bit wrong after load");

  chk_port_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (en_in && !loaded_q) |=>
    port_q == $past(strap_in.port_index))
    else $error("port index not loaded from strap");

  chk_straps_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loaded_q |=>
    $stable(port_q) && $stable(up_q) && $stable(phys_q))
    else $error("captured straps changed");

  chk_loaded_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loaded_q |=>
    loaded_q)
    else $error("loaded flag dropped without reset");

  chk_sdown_unlocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open |=>
    sdown_q == $past(bus_in.wdata[SDOWN_BIT]))
    else $error("unlocked write did not update sudden loss bit");

  chk_alive_unlocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open |=>
    alive_q == ($past(bus_in.wdata[ALIVE_BIT]) && !$past(up_q)))
    else $error("link alive bit wrong after unlocked write");

  chk_bwn_unlocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open |=>
    bwn_q == ($past(bus_in.wdata[BWN_BIT]) && !$past(up_q)))
    else $error("bandwidth notify bit wrong after unlocked write");

  chk_role_locked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wr_hit && !unlock_in && loaded_q) |=>
    $stable(sdown_q) && $stable(alive_q) && $stable(bwn_q))
    else $error("locked write changed a role bit");

  chk_unmapped_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (loaded_q && en_in && bus_in.wr && !plc_hit(bus_in)) |=>
    $stable(width_q) && $stable(l1_q) && $stable(sdown_q))
    else $error("unmapped write changed a field");

  chk_freeze_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !en_in |=>
    $stable(loaded_q) && $stable(width_q) && $stable(l1_q) && $stable(bwn_q))
    else $error("field changed while clock enable low");

  chk_freeze_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !en_in |=>
    $stable(rdata_q) && $stable(train_q))
    else $error("output changed while clock enable low");

  cov_unlocked_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open ##1 rd_hit);
  cov_narrow_train: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    loaded_q && train_q < phys_q);
  cov_invalid_train: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    loaded_q && !plc_width_valid(width_q));
  cov_locked_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_hit && !unlock_in && loaded_q);
  cov_upstream_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_open && up_q);
endmodule

// >>> testbench/plc_link_cap_tb_top.sv
// Self-checking testbench for the link capability register
`timescale 1ns/1ps
module plc_link_cap_tb_top;
  import plc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic en_in = 1'b1;
  plc_bus_s bus_in = '0;
  plc_strap_s strap_in = '0;
  logic unlock_in = 1'b0;
  logic common_clk_in = 1'b0;
  logic [31:0] rdata_out;
  logic [5:0] train_width_out;
  logic loaded_out;
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] rd_q;

  plc_link_cap plc_link_cap_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(en_in),
    .bus_in(bus_in), .strap_in(strap_in), .unlock_in(unlock_in),
    .common_clk_in(common_clk_in), .rdata_out(rdata_out),
    .train_width_out(train_width_out), .loaded_out(loaded_out));

  always #2 clk_in = ~clk_in;

  function automatic logic [31:0] exp_word(input logic [5:0] w, input logic [2:0] l0s,
      input logic [2:0] l1, input logic [2:0] role, input logic [7:0] port);
    exp_word = {port, 2'h0, role, REFCLK_REMOVAL, l1, l0s, ASPM_L0S_L1, w, SPEED_GEN1};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask

  // Read data is taken in the one cycle where it stands
  task automatic bus_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1 rd_q = rdata_out;
  endtask

  task automatic check_train(input logic [5:0] exp);
    repeat (2) @(posedge clk_in);
    #1 chk("train_width", {26'h0, exp}, {26'h0, train_width_out});
  endtask

  task automatic do_reset(input plc_strap_s s);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    strap_in <= s;
    unlock_in <= 1'b0;
    common_clk_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk("train_width_in_reset", 32'h1, {26'h0, train_width_out});
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Straps land on the first edge after release, trained width one edge later
    @(posedge clk_in);
    #1 chk("loaded", 32'h1, {31'h0, loaded_out});
    @(posedge clk_in);
    #1 chk("train_width_loaded", {26'h0, s.phys_width}, {26'h0, train_width_out});
  endtask

  task automatic t_downstream_reset();
    do_reset('{8'h03, WIDTH_X8, 1'b0, 1'b0});
    bus_read(LINK_CAP_ADDR);
    chk("word_separate", exp_word(WIDTH_X8, L0S_SEPARATE, L1_RESET, 3'h7, 8'h03), rd_q);
    common_clk_in <= 1'b1;
    bus_read(LINK_CAP_ADDR);
    chk("word_common", exp_word(WIDTH_X8, L0S_COMMON, L1_RESET, 3'h7, 8'h03), rd_q);
  endtask

  // Locked, frozen and unlocked writes of all ones on a x8 downstream port
  task automatic t_lock_and_write();
    bus_write(LINK_CAP_ADDR, 32'hffff_ffff);
    bus_read(LINK_CAP_ADDR);
    chk("word_locked", exp_word(WIDTH_X8, L0S_COMMON, L1_RESET, 3'h7, 8'h03), rd_q);
    unlock_in <= 1'b1;
    en_in <= 1'b0;
    bus_write(LINK_CAP_ADDR, 32'hffff_ffff);
    en_in <= 1'b1;
    bus_read(LINK_CAP_ADDR);
    chk("word_frozen", exp_word(WIDTH_X8, L0S_COMMON, L1_RESET, 3'h7, 8'h03), rd_q);
    bus_write(LINK_CAP_ADDR + 12'h004, 32'hffff_ffff);
    bus_write(LINK_CAP_ADDR, 32'hffff_ffff);
    check_train(WIDTH_X1);
    bus_read(LINK_CAP_ADDR);
    chk("word_unlocked", exp_word(6'h3f, L0S_COMMON, 3'h7, 3'h7, 8'h03), rd_q);
  endtask

  task automatic t_width_codes();
    logic [5:0] code [5] = '{WIDTH_X4, 6'h00, 6'h03, WIDTH_X2, WIDTH_X32};
    logic [5:0] want [5] = '{WIDTH_X4, WIDTH_X1, WIDTH_X1, WIDTH_X2, WIDTH_X8};
    for (int i = 0; i < 5; i++) begin
      bus_write(LINK_CAP_ADDR, {22'h0, code[i], 4'h0});
      check_train(want[i]);
    end
  endtask

  // Unmapped reads give zero and read data stands for one cycle only
  task automatic t_unmapped();
    bus_read(LINK_CAP_ADDR + 12'h004);
    chk("unmapped_read", 32'h0, rd_q);
    bus_read(LINK_CAP_ADDR);
    chk("word_coded", exp_word(WIDTH_X32, L0S_COMMON, 3'h0, 3'h0, 8'h03), rd_q);
    @(posedge clk_in);
    #1 chk("read_after", 32'h0, rdata_out);
  endtask

  task automatic t_upstream();
    do_reset('{8'h06, WIDTH_X4, 1'b1, 1'b0});
    bus_read(LINK_CAP_ADDR);
    chk("word_upstream", exp_word(WIDTH_X4, L0S_SEPARATE, L1_RESET, 3'h0, 8'h06), rd_q);
    unlock_in <= 1'b1;
    bus_write(LINK_CAP_ADDR, 32'hffff_ffff);
    bus_read(LINK_CAP_ADDR);
    chk("upstream_written", exp_word(6'h3f, L0S_SEPARATE, 3'h7, 3'h1, 8'h06), rd_q);
  endtask

  task automatic t_compat();
    do_reset('{8'h00, WIDTH_X16, 1'b0, 1'b1});
    bus_read(LINK_CAP_ADDR);
    chk("word_compat", exp_word(WIDTH_X16, L0S_SEPARATE, L1_RESET, 3'h3, 8'h00), rd_q);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run is under a hundred cycles; this leaves ample margin
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end

  initial begin
    t_downstream_reset();
    t_lock_and_write();
    t_width_codes();
    t_unmapped();
    t_upstream();
    t_compat();
    give_verdict();
  end
endmodule
